//--- rtl/ccpcu_pkg.sv
package ccpcu_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0C;
    localparam logic [7:0] IDX_T1_LOW = 8'h0E;
    localparam logic [7:0] IDX_T1_HIGH = 8'h0F;
    localparam logic [7:0] IDX_T1_CTRL = 8'h10;
    localparam logic [7:0] IDX_T2_COUNT = 8'h11;
    localparam logic [7:0] IDX_T2_CTRL = 8'h12;
    localparam logic [7:0] IDX_VAL_LOW = 8'h15;
    localparam logic [7:0] IDX_VAL_HIGH = 8'h16;
    localparam logic [7:0] IDX_UNIT_CTRL = 8'h17;
    localparam logic [7:0] IDX_PORT_DIR = 8'h87;
    localparam logic [7:0] IDX_IRQ_EN = 8'h8C;
    localparam logic [7:0] IDX_PERIOD = 8'h92;
    localparam int ADDR_W = 10;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'hFF;
    localparam logic [7:0] RST_PERIOD = 8'hFF;

    // Field positions
    localparam int FLAG_T1_OVF = 0;
    localparam int FLAG_T2_MATCH = 1;
    localparam int FLAG_CCP_EVENT = 2;
    localparam logic [7:0] FLAG_MASK = 8'h07;
    localparam int T1_ON_BIT = 0;
    localparam logic [7:0] T1_CTRL_MASK = 8'h3F;
    localparam int T2_ON_BIT = 2;
    localparam int T2_PRE_LSB = 0;
    localparam int T2_POST_LSB = 3;
    localparam logic [7:0] T2_CTRL_MASK = 8'h7F;
    localparam int DUTY_LSB_ZERO_BIT = 4;
    localparam int DUTY_LSB_ONE_BIT = 5;
    localparam logic [7:0] UNIT_CTRL_MASK = 8'h3F;
    localparam int PIN_DIR_BIT = 2;

    // Mode field codes
    localparam logic [3:0] MODE_SET_ON_MATCH = 4'h8;
    localparam logic [3:0] MODE_CLR_ON_MATCH = 4'h9;
    localparam logic [3:0] MODE_SW_EVENT = 4'hA;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    localparam logic [1:0] MODE_PWM_TOP = 2'h3;

    // Timer2 prescale select codes
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;

    // Quarter phases per instruction cycle
    localparam logic [1:0] PHASE_LAST = 2'h3;
endpackage

//--- rtl/ccpcu_unit.sv
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - Writing zero to the unit control forces the compare latch low.
// - Software event match sets the event flag, pin untouched.
// - Special trigger match clears the event timer and, with adc_enabled high, starts conversion.
// - The special trigger clear never sets the overflow flag.
// - PWM mode drives the pin with up to ten bits of duty.
// - Writing zero to the unit control forces the PWM latch low.
// - Period timer clears on the increment after equalling the limit.
// - That rollover sets the pin unless the duty is zero.
// - Rollover copies low duty and its two bits into the shadow.
// - The postscaler only divides match flags, not the period.
// - Duty is low value as top eight bits, control 5:4 below.
// - Duty writes apply next period; shadow is read-only in PWM.
// - Duty is double buffered in shadow plus hidden two-bit latch.
// - Pin clears when shadow duty equals count with two phase bits, or two prescaler bits at prescale 4 or 16.
// - Duty longer than the period never clears the pin.
// - Compare value matches the event timer continuously; only set and clear modes move the pin.
// - Period timer prescale is 1, 4 or 16 instruction cycles.
module ccpcu_unit (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [ccpcu_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic adc_enabled,
    output logic adc_start,
    output logic ccp_output_pin,
    output logic ccp_output_pin_en,
    output logic irq_request
);
    import ccpcu_pkg::*;

    logic waitreq_reg;
    logic [31:0] rdata_reg;
    logic [7:0] flags_reg;
    logic [7:0] enables_reg;
    logic [7:0] t1_ctrl_reg;
    logic [15:0] t1_count_reg;
    logic [7:0] t2_ctrl_reg;
    logic [7:0] t2_count_reg;
    logic [7:0] period_reg;
    logic [7:0] val_low_reg;
    logic [7:0] val_high_reg;
    logic [7:0] unit_ctrl_reg;
    logic [7:0] port_dir_reg;
    logic [1:0] duty_lsb_reg;
    logic [1:0] phase_reg;
    logic [3:0] pre_reg;
    logic [3:0] post_reg;
    logic match_prev_reg;
    logic out_latch_reg;
    logic pin_en_reg;
    logic adc_start_reg;
    logic irq_reg;

    // Bus decode: one wait state, then the access completes
    logic [7:0] idx;
    logic aligned;
    logic wr_fire;
    assign idx = avs_address[ADDR_W-1:2];
    assign aligned = (avs_address[1:0] == 2'h0);
    assign wr_fire = avs_write & ~waitreq_reg & aligned;
    logic [7:0] wdata;
    assign wdata = avs_writedata[7:0];

    logic wr_flags, wr_t1l, wr_t1h, wr_t1c, wr_t2, wr_t2c;
    logic wr_vl, wr_vh, wr_uc, wr_dir, wr_en, wr_per;
    assign wr_flags = wr_fire & (idx == IDX_IRQ_FLAGS);
    assign wr_t1l = wr_fire & (idx == IDX_T1_LOW);
    assign wr_t1h = wr_fire & (idx == IDX_T1_HIGH);
    assign wr_t1c = wr_fire & (idx == IDX_T1_CTRL);
    assign wr_t2 = wr_fire & (idx == IDX_T2_COUNT);
    assign wr_t2c = wr_fire & (idx == IDX_T2_CTRL);
    assign wr_vl = wr_fire & (idx == IDX_VAL_LOW);
    assign wr_vh = wr_fire & (idx == IDX_VAL_HIGH);
    assign wr_uc = wr_fire & (idx == IDX_UNIT_CTRL);
    assign wr_dir = wr_fire & (idx == IDX_PORT_DIR);
    assign wr_en = wr_fire & (idx == IDX_IRQ_EN);
    assign wr_per = wr_fire & (idx == IDX_PERIOD);

    // Read mux; unmapped or unaligned addresses read zero
    logic [7:0] rd_byte;
    assign rd_byte =
        !aligned ? RST_ZERO :
        (idx == IDX_IRQ_FLAGS) ? flags_reg :
        (idx == IDX_T1_LOW) ? t1_count_reg[7:0] :
        (idx == IDX_T1_HIGH) ? t1_count_reg[15:8] :
        (idx == IDX_T1_CTRL) ? t1_ctrl_reg :
        (idx == IDX_T2_COUNT) ? t2_count_reg :
        (idx == IDX_T2_CTRL) ? t2_ctrl_reg :
        (idx == IDX_VAL_LOW) ? val_low_reg :
        (idx == IDX_VAL_HIGH) ? val_high_reg :
        (idx == IDX_UNIT_CTRL) ? unit_ctrl_reg :
        (idx == IDX_PORT_DIR) ? port_dir_reg :
        (idx == IDX_IRQ_EN) ? enables_reg :
        (idx == IDX_PERIOD) ? period_reg : RST_ZERO;

    logic waitreq_next;
    assign waitreq_next = ~((avs_read | avs_write) & waitreq_reg);

    // Bus handshake registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            waitreq_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            waitreq_reg <= waitreq_next;
            if (avs_read & waitreq_reg)
                rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // Mode decode
    logic [3:0] mode;
    logic is_pwm, is_set, is_clr, is_sw, is_spec, is_cmp;
    assign mode = unit_ctrl_reg[3:0];
    assign is_pwm = (mode[3:2] == MODE_PWM_TOP);
    assign is_set = (mode == MODE_SET_ON_MATCH);
    assign is_clr = (mode == MODE_CLR_ON_MATCH);
    assign is_sw = (mode == MODE_SW_EVENT);
    assign is_spec = (mode == MODE_SPECIAL);
    assign is_cmp = is_set | is_clr | is_sw | is_spec;

    // Instruction cycle enable: one pulse every four core clocks
    logic instr_tick;
    assign instr_tick = (phase_reg == PHASE_LAST);

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            phase_reg <= 2'h0;
        else
            phase_reg <= phase_reg + 2'h1;
    end

    // Compare against the event timer, fired on the rising match
    logic cmp_equal, cmp_fire, spec_fire;
    assign cmp_equal = (t1_count_reg == {val_high_reg, val_low_reg});
    assign cmp_fire = is_cmp & cmp_equal & ~match_prev_reg;
    assign spec_fire = cmp_fire & is_spec;

    // Event timer: counts instruction cycles while enabled
    logic t1_run, t1_ovf;
    assign t1_run = instr_tick & t1_ctrl_reg[T1_ON_BIT];
    assign t1_ovf = t1_run & (t1_count_reg == 16'hFFFF) &
        ~spec_fire;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            t1_count_reg <= 16'h0000;
            match_prev_reg <= 1'b0;
        end
        else
        begin
            match_prev_reg <= is_cmp & cmp_equal;
            if (spec_fire)
                t1_count_reg <= 16'h0000;
            else if (wr_t1l)
                t1_count_reg[7:0] <= wdata;
            else if (wr_t1h)
                t1_count_reg[15:8] <= wdata;
            else if (t1_run)
                t1_count_reg <= t1_count_reg + 16'h0001;
        end
    end

    // Period timer prescaler and increment enable
    logic [1:0] pre_sel;
    logic t2_on, t2_inc, t2_roll, post_hit, clr_scalers;
    assign pre_sel = t2_ctrl_reg[T2_PRE_LSB +: 2];
    assign t2_on = t2_ctrl_reg[T2_ON_BIT];
    assign t2_inc = instr_tick & t2_on & (
        (pre_sel == PRE_DIV1) ? 1'b1 :
        (pre_sel == PRE_DIV4) ? (pre_reg[1:0] == 2'h3) :
        (pre_reg == 4'hF));
    assign t2_roll = t2_inc & (t2_count_reg == period_reg);
    assign post_hit = (post_reg == t2_ctrl_reg[T2_POST_LSB +: 4]);
    assign clr_scalers = wr_t2 | wr_t2c;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pre_reg <= 4'h0;
            post_reg <= 4'h0;
            t2_count_reg <= RST_ZERO;
        end
        else
        begin
            if (clr_scalers)
                pre_reg <= 4'h0;
            else if (instr_tick & t2_on)
                pre_reg <= pre_reg + 4'h1;
            if (clr_scalers)
                post_reg <= 4'h0;
            else if (t2_roll)
                post_reg <= post_hit ? 4'h0 : post_reg + 4'h1;
            if (wr_t2)
                t2_count_reg <= wdata;
            else if (t2_roll)
                t2_count_reg <= RST_ZERO;
            else if (t2_inc)
                t2_count_reg <= t2_count_reg + 8'h01;
        end
    end

    // Duty value and its match against count extended by two phase bits, or prescaler bits at prescale 4 or 16
    logic [9:0] duty_new, duty_shadow, count_ext;
    logic [1:0] sub_bits;
    logic duty_match;
    assign duty_new = {val_low_reg,
        unit_ctrl_reg[DUTY_LSB_ONE_BIT], unit_ctrl_reg[DUTY_LSB_ZERO_BIT]};
    assign duty_shadow = {val_high_reg, duty_lsb_reg};
    assign sub_bits = (pre_sel == PRE_DIV1) ? phase_reg :
        (pre_sel == PRE_DIV4) ? pre_reg[1:0] : pre_reg[3:2];
    assign count_ext = {t2_count_reg, sub_bits};
    // A duty beyond the period never reaches equality, so the pin stays high
    assign duty_match = (duty_shadow == count_ext);
    // Clear one count step early, so the registered pin is high for duty
    logic sub_step, clear_early;
    assign sub_step = t2_on & ((pre_sel == PRE_DIV1) | (instr_tick &
        ((pre_sel == PRE_DIV4) | (pre_reg[1:0] == 2'h3))));
    assign clear_early = sub_step & (count_ext + 10'h001 == duty_shadow);

    // Shared compare/PWM output latch
    logic ctrl_zero;
    assign ctrl_zero = wr_uc & (wdata == RST_ZERO);

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            out_latch_reg <= 1'b0;
        else if (ctrl_zero)
            out_latch_reg <= 1'b0;
        else if (is_pwm & t2_roll)
            out_latch_reg <= (duty_new != 10'h000);
        else if (is_pwm & (duty_match | clear_early))
            out_latch_reg <= 1'b0;
        else if (cmp_fire & is_set)
            out_latch_reg <= 1'b1;
        else if (cmp_fire & is_clr)
            out_latch_reg <= 1'b0;
    end

    // Compare value, control, period and direction registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            val_low_reg <= RST_ZERO;
            val_high_reg <= RST_ZERO;
            duty_lsb_reg <= 2'h0;
            unit_ctrl_reg <= RST_ZERO;
            period_reg <= RST_PERIOD;
            port_dir_reg <= RST_PORT_DIR;
            t1_ctrl_reg <= RST_ZERO;
            t2_ctrl_reg <= RST_ZERO;
            enables_reg <= RST_ZERO;
        end
        else
        begin
            if (wr_vl)
                val_low_reg <= wdata;
            if (is_pwm & t2_roll)
            begin
                val_high_reg <= val_low_reg;
                duty_lsb_reg <= duty_new[1:0];
            end
            else if (wr_vh & ~is_pwm)
                val_high_reg <= wdata;
            if (wr_uc)
                unit_ctrl_reg <= wdata & UNIT_CTRL_MASK;
            if (wr_per)
                period_reg <= wdata;
            if (wr_dir)
                port_dir_reg <= wdata;
            if (wr_t1c)
                t1_ctrl_reg <= wdata & T1_CTRL_MASK;
            if (wr_t2c)
                t2_ctrl_reg <= wdata & T2_CTRL_MASK;
            if (wr_en)
                enables_reg <= wdata & FLAG_MASK;
        end
    end

    // Sticky flags; a hardware set wins over a software clear
    logic [7:0] flag_set;
    assign flag_set = {5'h00, cmp_fire, t2_roll & post_hit, t1_ovf};

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            flags_reg <= RST_ZERO;
        else if (wr_flags)
            flags_reg <= (wdata & FLAG_MASK) | flag_set;
        else
            flags_reg <= flags_reg | flag_set;
    end

    // Output registers
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_en_reg <= 1'b0;
            adc_start_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            pin_en_reg <= ~port_dir_reg[PIN_DIR_BIT] &
                (is_cmp | is_pwm);
            adc_start_reg <= spec_fire & adc_enabled;
            irq_reg <= |(flags_reg & enables_reg);
        end
    end

    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign adc_start = adc_start_reg;
    assign ccp_output_pin = out_latch_reg;
    assign ccp_output_pin_en = pin_en_reg;
    assign irq_request = irq_reg;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence roll_s;
        is_pwm & t2_roll & ~ctrl_zero;
    endsequence

    sequence shadow_loaded_s;
        val_high_reg == $past(val_low_reg) &&
            duty_lsb_reg == $past(duty_new[1:0]);
    endsequence

    chk_ctrl_zero_low: assert property (
        ctrl_zero |=> !ccp_output_pin)
        else $error("output latch not low after control cleared");

    chk_sw_event_flag: assert property (
        cmp_fire & is_sw & ~ctrl_zero |=>
            flags_reg[FLAG_CCP_EVENT] &&
            ccp_output_pin == $past(ccp_output_pin))
        else $error("software event did not flag or moved the pin");

    chk_special_clear: assert property (
        spec_fire |=> t1_count_reg == 16'h0000 &&
            adc_start == $past(adc_enabled) ##1 !adc_start)
        else $error("special trigger did not clear timer or start");

    chk_no_ovf_flag: assert property (
        spec_fire & ~flags_reg[FLAG_T1_OVF] & ~wr_flags |=>
            !flags_reg[FLAG_T1_OVF])
        else $error("special trigger set the overflow flag");

    chk_period_roll: assert property (
        t2_inc & (t2_count_reg == period_reg) & ~wr_t2 |=>
            t2_count_reg == 8'h00)
        else $error("period timer did not clear at limit");

    chk_pwm_set: assert property (
        roll_s |=> ccp_output_pin == ($past(duty_new) != 10'h000))
        else $error("pin wrong at period rollover");

    chk_shadow_load: assert property (
        roll_s |=> shadow_loaded_s)
        else $error("duty not copied into shadow at rollover");

    chk_pwm_clear: assert property (
        is_pwm & duty_match & ~t2_roll & ~ctrl_zero |=> !ccp_output_pin)
        else $error("pin not cleared on duty match");

    chk_shadow_readonly: assert property (
        wr_vh & is_pwm & ~t2_roll |=> $stable(val_high_reg))
        else $error("shadow written in PWM mode");

    chk_bus_wait: assert property (
        (avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest
            ##1 avs_waitrequest)
        else $error("bus answer not after one wait state");
endmodule

//--- testbench/ccpcu_far_model.sv
`timescale 1ns/1ps
module ccpcu_far_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic converter_on,
    input wire logic adc_start,
    input wire logic ccp_output_pin,
    input wire logic ccp_output_pin_en,
    output logic adc_enabled,
    output logic pin_level,
    output logic [7:0] start_count
);
    // Converter reports ready only while the bench turns it on
    assign adc_enabled = converter_on;
    // Pin has a pull-down, so an undriven pin reads low
    assign pin_level = ccp_output_pin_en ? ccp_output_pin : 1'b0;
    // Counts conversions that the converter really accepts
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            start_count <= 8'h00;
        else if (adc_start && adc_enabled)
            start_count <= start_count + 8'h01;
    end
endmodule

//--- testbench/ccpcu_unit_tb.sv
`timescale 1ns/1ps
module ccpcu_unit_tb;
    import ccpcu_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic adc_enabled;
    logic adc_start;
    logic ccp_output_pin;
    logic ccp_output_pin_en;
    logic irq_request;
    logic converter_on = 1'b0;
    logic pin_level;
    logic [7:0] start_count;
    logic [7:0] s0;
    logic [31:0] rd;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int per;
    int hi;
    int duty;
    logic [7:0] ridx [6] = '{IDX_PERIOD, IDX_PORT_DIR, IDX_UNIT_CTRL,
        IDX_T2_COUNT, IDX_IRQ_FLAGS, 8'h40};
    logic [7:0] rexp [6] = '{RST_PERIOD, RST_PORT_DIR, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO};
    logic [7:0] cmode [4] = '{8'h08, 8'h09, 8'h0A, 8'h08};
    logic cpin [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] pr [6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
    logic [7:0] vl [6] = '{8'h01, 8'h01, 8'h00, 8'h10, 8'h01, 8'h01};
    logic [1:0] lsb [6] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0};
    logic [7:0] t2c [6] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h7C, 8'h05};
    int unit [6] = '{1, 1, 1, 1, 1, 4};

    // Clock at 100 MHz
    always #5 core_clk = ~core_clk;

    ccpcu_unit u_ccpcu_unit (
        .core_clk(core_clk),
        .reset(reset),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .adc_enabled(adc_enabled),
        .adc_start(adc_start),
        .ccp_output_pin(ccp_output_pin),
        .ccp_output_pin_en(ccp_output_pin_en),
        .irq_request(irq_request)
    );

    ccpcu_far_model u_ccpcu_far_model (
        .core_clk(core_clk),
        .reset(reset),
        .converter_on(converter_on),
        .adc_start(adc_start),
        .ccp_output_pin(ccp_output_pin),
        .ccp_output_pin_en(ccp_output_pin_en),
        .adc_enabled(adc_enabled),
        .pin_level(pin_level),
        .start_count(start_count)
    );

    // Prints the counts and the verdict, then ends the run
    task automatic stop_test;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compares a seen value with the expected one
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
        input logic [7:0] data);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, data};
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge core_clk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // Reads a register and compares it
    task automatic rdchk(input string name, input logic [7:0] idx,
        input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(name, rd, {24'h0, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Cuts a hung run short
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        idle(2);
        check("pin enable idle", 32'(ccp_output_pin_en), 32'h0);
        for (int i = 0; i < 6; i++)
            rdchk("reset value", ridx[i], rexp[i]);
        // Compare set-up: value 0x0010, pin made an output, timer running
        bus(1'b1, IDX_VAL_LOW, 8'h10);
        bus(1'b1, IDX_VAL_HIGH, 8'h00);
        bus(1'b1, IDX_PORT_DIR, 8'hFB);
        bus(1'b1, IDX_IRQ_EN, 8'h04);
        bus(1'b1, IDX_T1_CTRL, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, IDX_UNIT_CTRL, cmode[i]);
            bus(1'b1, IDX_IRQ_FLAGS, 8'h00);
            bus(1'b1, IDX_T1_LOW, 8'h00);
            bus(1'b1, IDX_T1_HIGH, 8'h00);
            idle(120);
            check("compare pin", 32'(pin_level), 32'(cpin[i]));
            rdchk("event flag", IDX_IRQ_FLAGS, 8'h04);
            check("irq", 32'(irq_request), 32'h1);
        end
        bus(1'b1, IDX_UNIT_CTRL, 8'h00);
        idle(2);
        check("compare latch", 32'(ccp_output_pin), 32'h0);
        // Special trigger at the top of the count, converter on, then off
        converter_on <= 1'b1;
        bus(1'b1, IDX_VAL_LOW, 8'hFF);
        bus(1'b1, IDX_VAL_HIGH, 8'hFF);
        bus(1'b1, IDX_IRQ_FLAGS, 8'h00);
        bus(1'b1, IDX_T1_HIGH, 8'hFF);
        bus(1'b1, IDX_T1_LOW, 8'hE0);
        bus(1'b1, IDX_UNIT_CTRL, 8'(MODE_SPECIAL));
        idle(150);
        check("start seen", 32'(start_count), 32'h1);
        rdchk("timer high", IDX_T1_HIGH, 8'h00);
        bus(1'b0, IDX_T1_LOW, 8'h00);
        check("timer cleared", 32'(rd <= 32'h10), 32'h1);
        rdchk("no overflow flag", IDX_IRQ_FLAGS, 8'h04);
        converter_on <= 1'b0;
        s0 = start_count;
        bus(1'b1, IDX_T1_HIGH, 8'hFF);
        bus(1'b1, IDX_T1_LOW, 8'hE0);
        idle(150);
        check("start gated", 32'(start_count), 32'(s0));
        rdchk("timer high again", IDX_T1_HIGH, 8'h00);
        bus(1'b1, IDX_UNIT_CTRL, 8'h00);
        bus(1'b1, IDX_T1_CTRL, 8'h00);
        // PWM table, set up in the documented order
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, IDX_PERIOD, pr[i]);
            bus(1'b1, IDX_VAL_LOW, vl[i]);
            bus(1'b1, IDX_PORT_DIR, 8'hFB);
            bus(1'b1, IDX_T2_CTRL, t2c[i]);
            bus(1'b1, IDX_UNIT_CTRL, {2'b00, lsb[i], 4'hC});
            per = (int'(pr[i]) + 1) * 4 * unit[i];
            idle(2 * per + 8);
            hi = 0;
            repeat (10 * per)
            begin
                @(posedge core_clk);
                if (pin_level === 1'b1)
                    hi++;
            end
            duty = int'(vl[i]) * 4 + int'(lsb[i]);
            if (duty > (int'(pr[i]) + 1) * 4)
                duty = (int'(pr[i]) + 1) * 4;
            duty = duty * unit[i] * 10;
            check("pwm high", 32'(hi), 32'(duty));
            rdchk("duty shadow", IDX_VAL_HIGH, vl[i]);
            check("pwm pin enable", 32'(ccp_output_pin_en), 32'h1);
        end
        bus(1'b1, IDX_VAL_HIGH, 8'h55);
        rdchk("shadow read only", IDX_VAL_HIGH, 8'h01);
        bus(1'b1, IDX_VAL_LOW, 8'h10);
        idle(120);
        check("pwm full duty", 32'(pin_level), 32'h1);
        bus(1'b1, IDX_UNIT_CTRL, 8'h00);
        idle(2);
        check("pwm latch", 32'(ccp_output_pin), 32'h0);
        stop_test();
    end
endmodule
